// ===== pkg/kbi_pkg.sv
`default_nettype none
package kbi_pkg;
  localparam int         ADDR_W          = 8;
  localparam int         DATA_W          = 8;
  localparam int         KEY_N           = 6;
  localparam int         EVT_N           = 2;

  localparam logic [7:0] OFF_STATUS_CTRL = 8'h1A;
  localparam logic [7:0] OFF_KEY_ENABLE  = 8'h1B;
  localparam logic [7:0] OFF_EVT_STATUS  = 8'h30;
  localparam logic [7:0] OFF_EVT_MASK    = 8'h31;

  localparam int         BIT_MODE        = 0;
  localparam int         BIT_IMASK       = 1;
  localparam int         BIT_ACK         = 2;
  localparam int         BIT_PENDING     = 3;
  localparam int         BIT_AWU_EN      = 6;
  localparam int         BIT_EVT_KEY     = 0;
  localparam int         BIT_EVT_AWU     = 1;

  localparam logic [15:0] KEY_VECTOR_ADDR = 16'hFFE0;

  localparam logic [5:0] RST_PINS        = 6'h3F;
  localparam logic [5:0] RST_KEY_EN      = 6'h00;
  localparam logic [1:0] RST_EVT         = 2'h0;
  localparam logic [7:0] RST_DATA        = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic              wrStb;
    logic              rdStb;
  } kbi_bus_s;

  typedef struct packed {
    logic [KEY_N-1:0]  pinMeta;
    logic [KEY_N-1:0]  pinSync;
    logic [KEY_N-1:0]  pinPrev;
    logic              awuMeta;
    logic              awuSync;
    logic              awuPrev;
    logic              keyLatch;
    logic              ackSeen;
    logic              awuLatch;
    logic              modeBit;
    logic              maskBit;
    logic [KEY_N-1:0]  keyEn;
    logic              awuEn;
    logic [EVT_N-1:0]  evtStat;
    logic [EVT_N-1:0]  evtMask;
    logic              cpuIrq;
    logic              intOut;
    logic [15:0]       vecAddr;
    logic [DATA_W-1:0] rdData;
  } kbi_state_s;

  localparam kbi_state_s ST_RESET = '{
    pinMeta:  RST_PINS,
    pinSync:  RST_PINS,
    pinPrev:  RST_PINS,
    awuMeta:  1'b0,
    awuSync:  1'b0,
    awuPrev:  1'b0,
    keyLatch: 1'b0,
    ackSeen:  1'b0,
    awuLatch: 1'b0,
    modeBit:  1'b0,
    maskBit:  1'b0,
    keyEn:    RST_KEY_EN,
    awuEn:    1'b0,
    evtStat:  RST_EVT,
    evtMask:  RST_EVT,
    cpuIrq:   1'b0,
    intOut:   1'b0,
    vecAddr:  KEY_VECTOR_ADDR,
    rdData:   RST_DATA
  };
endpackage
`default_nettype wire

// ===== core/kbi_core.sv
// Operation
// - In edge-and-level mode inputs sense low levels too; clearing needs ack and all high.
// - A keypad vector fetch gives an internal acknowledge that clears the request.
// - Writing one to the acknowledge bit acts like a vector fetch acknowledge and also clears the auto-wakeup request.
// - An acknowledge never masks later edges; a falling edge after it sets a new request.
// - Unmasked and pending, the processor is steered to the keypad vector at FFE0/FFE1.
// - In edge-and-level mode the request stays set while any enabled input is low.
// - The auto-wakeup request clears only on a software acknowledge or reset.
// - In edge-and-level mode acknowledge and all-inputs-high may come in either order.
// - With the mode bit clear only falling edges count and an acknowledge clears at once.
// - Reset clears the pending request and the mode bit even with an input held low.
// - A readable pending flag shows the latched request whatever the mask bit is.
`default_nettype none
module kbi_core
  import kbi_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire kbi_bus_s          bus,
  output logic [DATA_W-1:0]      rdData,
  input  wire logic [KEY_N-1:0]  kbdPin,
  input  wire logic              awuReq,
  input  wire logic              vecFetch,
  output logic                   cpuIrq,
  output logic [15:0]            vecAddr,
  output logic                   intr
);

  kbi_state_s st_r;
  kbi_state_s st_nxt;

  function automatic logic regHit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] off
  );
    regHit = (addr == off);
  endfunction

  logic [KEY_N-1:0] keyFall;
  logic             anyLow;
  logic             swAck;
  logic             anyAck;
  logic             awuRise;
  logic             keySet;
  logic             keyClr;
  logic             awuSet;
  logic             pending;
  logic             ackDone;
  logic [EVT_N-1:0] evtNew;
  logic [EVT_N-1:0] evtClr;
  logic [DATA_W-1:0] rdMux;

  always_comb begin
    st_nxt = st_r;

    // Two stages before any logic looks at the pins
    st_nxt.pinMeta = kbdPin;
    st_nxt.pinSync = st_r.pinMeta;
    st_nxt.pinPrev = st_r.pinSync;
    st_nxt.awuMeta = awuReq;
    st_nxt.awuSync = st_r.awuMeta;
    st_nxt.awuPrev = st_r.awuSync;

    keyFall = st_r.pinPrev & ~st_r.pinSync & st_r.keyEn;
    anyLow  = |(~st_r.pinSync & st_r.keyEn);
    awuRise = st_r.awuSync & ~st_r.awuPrev & st_r.awuEn;

    swAck = bus.wrStb && regHit(bus.addr, OFF_STATUS_CTRL)
            && bus.wrData[BIT_ACK];
    anyAck = swAck | vecFetch;

    // Level sense also catches a low already present when the mode is switched on
    keySet = (|keyFall)
             | (st_r.modeBit & anyLow & ~st_r.keyLatch);
    ackDone = anyAck | st_r.ackSeen;

    if (st_r.modeBit) begin
      keyClr = ackDone & ~anyLow;
    end else begin
      keyClr = anyAck;
    end

    // A new edge in the clearing cycle keeps the request
    if (keySet) begin
      st_nxt.keyLatch = 1'b1;
    end else if (keyClr) begin
      st_nxt.keyLatch = 1'b0;
    end

    if (keySet || keyClr || !st_r.modeBit) begin
      st_nxt.ackSeen = 1'b0;
    end else if (anyAck && st_r.keyLatch) begin
      st_nxt.ackSeen = 1'b1;
    end

    awuSet = awuRise;
    if (awuSet) begin
      st_nxt.awuLatch = 1'b1;
    end else if (swAck) begin
      st_nxt.awuLatch = 1'b0;
    end

    pending = st_r.keyLatch | st_r.awuLatch;

    if (bus.wrStb && regHit(bus.addr, OFF_STATUS_CTRL)) begin
      st_nxt.modeBit = bus.wrData[BIT_MODE];
      st_nxt.maskBit = bus.wrData[BIT_IMASK];
    end

    if (bus.wrStb && regHit(bus.addr, OFF_KEY_ENABLE)) begin
      st_nxt.keyEn = bus.wrData[KEY_N-1:0];
      st_nxt.awuEn = bus.wrData[BIT_AWU_EN];
    end

    if (bus.wrStb && regHit(bus.addr, OFF_EVT_MASK)) begin
      st_nxt.evtMask = bus.wrData[EVT_N-1:0];
    end

    evtNew = '0;
    evtNew[BIT_EVT_KEY] = keySet;
    evtNew[BIT_EVT_AWU] = awuSet;
    evtClr = '0;
    if (bus.wrStb && regHit(bus.addr, OFF_EVT_STATUS)) begin
      evtClr = bus.wrData[EVT_N-1:0];
    end
    // Set beats write-one-to-clear
    st_nxt.evtStat = (st_r.evtStat & ~evtClr) | evtNew;
    st_nxt.intOut  = |(st_nxt.evtStat & st_nxt.evtMask);

    // Request to the core is masked, the polled flag is not
    st_nxt.cpuIrq  = (st_nxt.keyLatch | st_nxt.awuLatch) & ~st_nxt.maskBit;
    st_nxt.vecAddr = KEY_VECTOR_ADDR;

    rdMux = RST_DATA;
    if (regHit(bus.addr, OFF_STATUS_CTRL)) begin
      rdMux[BIT_PENDING] = pending;
      rdMux[BIT_IMASK]   = st_r.maskBit;
      rdMux[BIT_MODE]    = st_r.modeBit;
    end else if (regHit(bus.addr, OFF_KEY_ENABLE)) begin
      rdMux[KEY_N-1:0]   = st_r.keyEn;
      rdMux[BIT_AWU_EN]  = st_r.awuEn;
    end else if (regHit(bus.addr, OFF_EVT_STATUS)) begin
      rdMux[EVT_N-1:0]   = st_r.evtStat;
    end else if (regHit(bus.addr, OFF_EVT_MASK)) begin
      rdMux[EVT_N-1:0]   = st_r.evtMask;
    end

    // Read data stands for one cycle only, zero otherwise
    if (bus.rdStb) begin
      st_nxt.rdData = rdMux;
    end else begin
      st_nxt.rdData = RST_DATA;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData  = st_r.rdData;
  assign cpuIrq  = st_r.cpuIrq;
  assign vecAddr = st_r.vecAddr;
  assign intr    = st_r.intOut;

endmodule
`default_nettype wire

// ===== tb/kbi_asserts.sv
`default_nettype none
module kbi_asserts
  import kbi_pkg::*;
(
  input wire logic              clk,
  input wire logic              rstn,
  input wire kbi_bus_s          bus,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic [KEY_N-1:0]  kbdPin,
  input wire logic              awuReq,
  input wire logic              vecFetch,
  input wire logic              cpuIrq,
  input wire logic [15:0]       vecAddr,
  input wire logic              intr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic             modeR, maskR, awuEnR;
  logic [KEY_N-1:0] enR;
  logic [EVT_N-1:0] evMaskR;
  logic [1:0]       hiCnt;
  logic             awuMay;
  wire  wrCtl = bus.wrStb && bus.addr == OFF_STATUS_CTRL;
  wire  wrEn  = bus.wrStb && bus.addr == OFF_KEY_ENABLE;
  wire  rdCtl = bus.rdStb && bus.addr == OFF_STATUS_CTRL;
  wire  ack   = vecFetch || (wrCtl && bus.wrData[BIT_ACK]);
  wire  allHi = &(kbdPin | ~enR);
  // History restarts on enable writes: a newly enabled pin may still be mid-sync
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {modeR, maskR, awuEnR, enR, evMaskR, hiCnt, awuMay} <= '0;
    end else begin
      if (wrCtl) {maskR, modeR} <= bus.wrData[1:0];
      if (wrEn) {awuEnR, enR} <= bus.wrData[6:0];
      if (bus.wrStb && bus.addr == OFF_EVT_MASK) evMaskR <= bus.wrData[1:0];
      hiCnt <= (allHi && !wrEn) ? ((hiCnt == 2'h3) ? 2'h3 : hiCnt + 2'h1) : 2'h0;
      // A latched wakeup outlives its enable until a software acknowledge
      awuMay <= awuEnR || (awuMay && !(wrCtl && bus.wrData[BIT_ACK]));
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  vec_addr_a: assert property (vecAddr == KEY_VECTOR_ADDR)
    else $error("vector address wrong");
  irq_mask_a: assert property (cpuIrq |-> !maskR)
    else $error("request passed the mask");
  ack_clears_a: assert property (ack && allHi && hiCnt == 2'h3 && !awuMay |=> !cpuIrq)
    else $error("acknowledge left request set");
  low_holds_a: assert property ((modeR && !maskR && !allHi) [*4] |-> cpuIrq)
    else $error("low level request dropped");
  pend_flag_a: assert property ($past(rdCtl && cpuIrq) |-> rdData[BIT_PENDING])
    else $error("pending flag missing");
  read_only_a: assert property (rdData != '0 |-> $past(bus.rdStb))
    else $error("read data outside read");
  intr_mask_a: assert property (intr |-> |evMaskR)
    else $error("interrupt while masked");
  reset_clear_a: assert property (disable iff (1'b0) !rstn |=> !cpuIrq && !intr)
    else $error("reset left request set");
  cover property (vecFetch && cpuIrq);
  cover property (modeR && cpuIrq && !allHi);
  cover property (intr);
endmodule
bind kbi_core kbi_asserts chk (.clk(clk), .rstn(rstn), .bus(bus), .rdData(rdData),
  .kbdPin(kbdPin), .awuReq(awuReq), .vecFetch(vecFetch), .cpuIrq(cpuIrq),
  .vecAddr(vecAddr), .intr(intr));
`default_nettype wire

// ===== tb/kbi_keypad.sv
`default_nettype none
module kbi_keypad
  import kbi_pkg::*;
(
  input  wire logic [KEY_N-1:0] press,
  output logic      [KEY_N-1:0] kbdPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Open switches read high through the pull-ups
  assign kbdPin = ~press;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none
module tb_top
  import kbi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rstn, awuReq, vecFetch, cpuIrq, intr;
  kbi_bus_s    bus;
  logic [7:0]  rdData;
  logic [5:0]  press, kbdPin;
  logic [15:0] vecAddr;
  int          bad_count, num_checks;
  kbi_keypad keys (.press(press), .kbdPin(kbdPin));
  kbi_core dut (.clk(clk), .rstn(rstn), .bus(bus), .rdData(rdData), .kbdPin(kbdPin),
    .awuReq(awuReq), .vecFetch(vecFetch), .cpuIrq(cpuIrq), .vecAddr(vecAddr), .intr(intr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic ck(input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1;
    ck(rdData, e);
  endtask
  task automatic key(input logic [5:0] v);
    @(posedge clk) press <= v;
    cyc(6);
  endtask
  task automatic fetch;
    @(posedge clk) vecFetch <= 1'b1;
    @(posedge clk) vecFetch <= 1'b0;
    cyc(1);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {rstn, awuReq, vecFetch, press, bus, bad_count, num_checks} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(OFF_STATUS_CTRL, 8'h00);
    rd(8'h55, 8'h00);
    ck(vecAddr, KEY_VECTOR_ADDR);
    wr(OFF_KEY_ENABLE, 8'h01);
    key(6'h01);
    rd(OFF_STATUS_CTRL, 8'h08);
    key(6'h00);
    ck(cpuIrq, 1'b1);
    fetch;
    ck(cpuIrq, 1'b0);
    key(6'h01);
    wr(OFF_STATUS_CTRL, 8'h04);
    ck(cpuIrq, 1'b0);
    key(6'h00);
    key(6'h01);
    ck(cpuIrq, 1'b1);
    wr(OFF_STATUS_CTRL, 8'h06);
    key(6'h00);
    key(6'h01);
    ck(cpuIrq, 1'b0);
    rd(OFF_STATUS_CTRL, 8'h0A);
    wr(OFF_STATUS_CTRL, 8'h05);
    cyc(2);
    ck(cpuIrq, 1'b1);
    fetch;
    cyc(2);
    ck(cpuIrq, 1'b1);
    key(6'h00);
    ck(cpuIrq, 1'b0);
    key(6'h01);
    key(6'h00);
    ck(cpuIrq, 1'b1);
    wr(OFF_STATUS_CTRL, 8'h05);
    ck(cpuIrq, 1'b0);
    key(6'h20);
    ck(cpuIrq, 1'b0);
    wr(OFF_EVT_MASK, 8'h01);
    ck(intr, 1'b1);
    wr(OFF_EVT_STATUS, 8'h01);
    ck(intr, 1'b0);
    wr(OFF_KEY_ENABLE, 8'h40);
    @(posedge clk) awuReq <= 1'b1;
    fetch;
    cyc(6);
    ck(cpuIrq, 1'b1);
    fetch;
    ck(cpuIrq, 1'b1);
    rd(OFF_EVT_STATUS, 8'h02);
    @(posedge clk) awuReq <= 1'b0;
    wr(OFF_STATUS_CTRL, 8'h04);
    ck(cpuIrq, 1'b0);
    wr(OFF_KEY_ENABLE, 8'h01);
    wr(OFF_STATUS_CTRL, 8'h01);
    key(6'h01);
    ck(cpuIrq, 1'b1);
    @(posedge clk) rstn <= 1'b0;
    @(posedge clk) rstn <= 1'b1;
    cyc(1);
    ck(cpuIrq, 1'b0);
    rd(OFF_STATUS_CTRL, 8'h00);
    results;
  end
endmodule
`default_nettype wire
